// *** ssdc_pkg.sv ***
// Constants and types for the serial slave shift front end with daisy chaining
// How it works
// - Decode only after nonzero multiple of eight clocks
// - Select release copies shift register to matrix
// - Select release after transfer clears diagnosis flags
// - Sample input and shift on falling clock
// - Update serial output on rising clock
// - Input words arrive most significant bit first
// - Frame is sixteen bits, control then data
// - Output word leaves most significant bit first
// - Output high impedance until select goes low
// - One shift register, displaced bit feeds output
// - Sixteen clocks finish one device, then release
// - Deselected: ignore clock and input, output off
// - Select fall loads diagnosis into shift register
// - Reset returns interface to default values
package ssdc_pkg;

  // Frame geometry
  localparam int unsigned FRAME_W  = 16;
  localparam int unsigned CNT_W    = 3;
  localparam int unsigned CHAN_N   = 8;
  localparam int unsigned SYNC_N   = 3;
  localparam int unsigned FIFO_D   = 8;

  // Frame field positions
  localparam int unsigned CMD_MSB  = 15;
  localparam int unsigned CMD_LSB  = 14;
  localparam int unsigned ADDR_MSB = 10;
  localparam int unsigned ADDR_LSB = 8;
  localparam int unsigned DATA_MSB = 7;

  // Reset values
  localparam logic [CNT_W-1:0]   CNT_RST   = 3'h0;
  localparam logic [FRAME_W-1:0] FRAME_RST = 16'h0000;
  localparam logic [CHAN_N-1:0]  FLAG_RST  = 8'h00;

  // Per channel diagnosis codes on the serial output
  localparam logic [1:0] CODE_SHORT_GND = 2'h0;
  localparam logic [1:0] CODE_OPEN_LOAD = 2'h1;
  localparam logic [1:0] CODE_PROTECT   = 2'h2;
  localparam logic [1:0] CODE_NORMAL    = 2'h3;

  // Received frame: control part then data part
  typedef struct packed {
    logic [1:0] cmd;
    logic [2:0] fixed;
    logic [2:0] addr;
    logic [7:0] data;
  } ssdc_frame_t;

  // One bit per channel for each diagnosis source
  typedef struct packed {
    logic [CHAN_N-1:0] prot;
    logic [CHAN_N-1:0] open_load;
    logic [CHAN_N-1:0] short_gnd;
  } ssdc_diag_t;

  // System side sequencing of a frame
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEL,
    ST_DONE
  } ssdc_state_t;

endpackage

// *** ssdc_fifo.sv ***
// Small synchronous FIFO with a registered output stage
`timescale 1ns/10ps
`default_nettype none

module ssdc_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 8
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem_reg [D];       // Storage words
  logic [AW:0]  wr_ptr_reg;        // Write pointer with wrap bit
  logic [AW:0]  rd_ptr_reg;        // Read pointer with wrap bit
  logic         out_valid_reg;     // Output stage holds a word
  logic [W-1:0] out_data_reg;      // Output stage word

  // Full when pointers differ only in the wrap bit
  wire logic full  = (wr_ptr_reg ^ rd_ptr_reg) == {1'b1, {AW{1'b0}}};
  wire logic empty = (wr_ptr_reg == rd_ptr_reg);
  wire logic push  = in_valid & ~full;
  // Refill output stage when it is empty or being taken
  wire logic pop   = ~empty & (~out_valid_reg | out_ready);

  assign in_ready  = ~full;
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= push ? (AW+1)'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_reg <= pop ? (AW+1)'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
    end
  end

  // Output stage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else if (pop) begin
      out_valid_reg <= 1'b1;
      out_data_reg  <= mem_reg[rd_ptr_reg[AW-1:0]];
    end else if (out_ready) begin
      out_valid_reg <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** ssdc_slave.sv ***
// Serial slave front end: link shift logic, frame check and diagnosis flags
`timescale 1ns/10ps
`default_nettype none

module ssdc_slave #(
  parameter int unsigned FIFO_DEPTH = ssdc_pkg::FIFO_D
) (
  // System clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Serial link pins
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               si_in,
  output logic                    so_out,
  output logic                    so_oe,
  // Diagnosis events from the channel logic
  input  wire ssdc_pkg::ssdc_diag_t diag_evt,
  output ssdc_pkg::ssdc_diag_t      diag_flags,
  // Received commands towards the decoder
  output logic                    cmd_valid,
  input  wire logic               cmd_ready,
  output ssdc_pkg::ssdc_frame_t     cmd_word,
  // Input matrix register and frame status
  output ssdc_pkg::ssdc_frame_t     imr_word,
  output logic                    frame_bad,
  output logic                    frame_lost
);

  import ssdc_pkg::*;

  // ------------------------------------------------------------
  // System domain state
  // ------------------------------------------------------------

  logic              link_clr_reg;   // Holds link logic clear in reset
  logic [SYNC_N-1:0] cs_q_reg;       // Select synchroniser chain
  logic              cs_lvl_reg;     // Accepted select level
  logic [SYNC_N-1:0] tog_q_reg;      // Frame start toggle chain
  logic              tog_lvl_reg;    // Accepted toggle level
  logic              tog_seen_reg;   // Toggle level of last frame
  ssdc_state_t       state_reg;      // Frame sequencer
  ssdc_state_t       state_next;
  logic              so_oe_reg;      // Output driver enable
  logic [FRAME_W-1:0] snap_reg;      // Diagnosis word for this frame
  logic [FRAME_W-1:0] snap_next;
  ssdc_diag_t        flags_reg;      // Latched diagnosis flags
  ssdc_diag_t        flags_next;
  ssdc_frame_t       imr_reg;        // Input matrix register
  logic              bad_reg;        // Rejected frame pulse
  logic              lost_reg;       // FIFO overrun pulse

  // ------------------------------------------------------------
  // Link domain state
  // ------------------------------------------------------------

  logic               started_reg;   // First falling edge seen
  logic [CNT_W-1:0]   cnt_reg;       // Clock count modulo eight
  logic               tog_reg;       // Flips once per clocked frame
  logic [FRAME_W-1:0] sr_reg;        // Shared shift register
  logic               so_reg;        // Serial output bit

  // ------------------------------------------------------------
  // Synchronisers for the select pin and the frame toggle
  // ------------------------------------------------------------

  // Link clear follows reset so link logic starts from constants
  always_ff @(posedge clk_sys) begin
    link_clr_reg <= ~rst_n;
  end

  // Three stages; only the later two are compared
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_q_reg  <= {SYNC_N{1'b1}};
      tog_q_reg <= '0;
    end else begin
      cs_q_reg  <= {cs_q_reg[SYNC_N-2:0], cs_n};
      tog_q_reg <= {tog_q_reg[SYNC_N-2:0], tog_reg};
    end
  end

  // A change counts once the second and third stages agree
  wire logic cs_agree  = (cs_q_reg[1] == cs_q_reg[2]);
  wire logic cs_new    = cs_agree ? cs_q_reg[2] : cs_lvl_reg;
  wire logic tog_agree = (tog_q_reg[1] == tog_q_reg[2]);
  wire logic tog_new   = tog_agree ? tog_q_reg[2] : tog_lvl_reg;
  wire logic cs_fall   = cs_lvl_reg & ~cs_new;
  wire logic cs_rise   = ~cs_lvl_reg & cs_new;

  // Accepted levels
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_lvl_reg  <= 1'b1;
      tog_lvl_reg <= 1'b0;
    end else begin
      cs_lvl_reg  <= cs_new;
      tog_lvl_reg <= tog_new;
    end
  end

  // ------------------------------------------------------------
  // Frame evaluation at select release
  // ------------------------------------------------------------

  // Frame had clocks if the toggle moved since the last frame
  wire logic had_clk   = (tog_lvl_reg != tog_seen_reg);
  // Count is a nonzero multiple of eight
  wire logic len_ok    = had_clk & (cnt_reg == CNT_RST);
  wire logic in_done   = (state_reg == ST_DONE);
  wire logic frame_ok  = in_done & len_ok;
  wire logic frame_rej = in_done & ~len_ok;
  wire logic fifo_rdy;
  // Link registers are quiet here: clock stopped, select high
  wire ssdc_frame_t rx_word = ssdc_frame_t'(sr_reg);

  // Sequencer: idle, selected, evaluate one cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cs_fall) begin
          state_next = ST_SEL;
        end
      end
      ST_SEL: begin
        if (cs_rise) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Output driver follows the accepted select level
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      so_oe_reg <= 1'b0;
    end else begin
      so_oe_reg <= ~cs_new;
    end
  end

  // Remember which toggle level closed the last frame
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tog_seen_reg <= 1'b0;
    end else if (in_done) begin
      tog_seen_reg <= tog_lvl_reg;
    end
  end

  // Matrix register takes only well formed frames
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      imr_reg <= ssdc_frame_t'(FRAME_RST);
    end else if (frame_ok) begin
      imr_reg <= rx_word;
    end
  end

  // Status pulses; a rejected frame leaves the matrix alone
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bad_reg  <= 1'b0;
      lost_reg <= 1'b0;
    end else begin
      bad_reg  <= frame_rej;
      lost_reg <= frame_ok & ~fifo_rdy;
    end
  end

  // ------------------------------------------------------------
  // Diagnosis flags and the outgoing word
  // ------------------------------------------------------------

  // Flags clear after a good frame; a new event wins the clear
  wire logic flag_clr = frame_ok;

  // Next flag state
  always_comb begin
    flags_next = flag_clr ? ssdc_diag_t'({3{FLAG_RST}}) : flags_reg;
    flags_next = flags_next | diag_evt;
  end

  // Flag register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags_reg <= ssdc_diag_t'({3{FLAG_RST}});
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Two bits per channel, channel seven in the top bits
  always_comb begin
    snap_next = FRAME_RST;
    for (int i = 0; i < CHAN_N; i++) begin
      if (flags_reg.short_gnd[i]) begin
        snap_next[2*i +: 2] = CODE_SHORT_GND;
      end else if (flags_reg.open_load[i]) begin
        snap_next[2*i +: 2] = CODE_OPEN_LOAD;
      end else if (flags_reg.prot[i]) begin
        snap_next[2*i +: 2] = CODE_PROTECT;
      end else begin
        snap_next[2*i +: 2] = CODE_NORMAL;
      end
    end
  end

  // Freeze the diagnosis word as the frame opens
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      snap_reg <= FRAME_RST;
    end else if (cs_fall) begin
      snap_reg <= snap_next;
    end
  end

  // ------------------------------------------------------------
  // Command buffer towards the decoder
  // ------------------------------------------------------------

  ssdc_fifo #(
    .W (FRAME_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (frame_ok),
    .in_ready  (fifo_rdy),
    .in_data   (sr_reg),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (cmd_word)
  );

  // ------------------------------------------------------------
  // Link domain: runs only on serial clock edges inside a frame
  // ------------------------------------------------------------

  // Marks the first falling edge; cleared while deselected
  always_ff @(negedge sclk or posedge cs_n or posedge link_clr_reg) begin
    if (cs_n || link_clr_reg) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  // Count falling edges modulo eight, flip toggle on the first
  always_ff @(negedge sclk or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      cnt_reg <= CNT_RST;
      tog_reg <= 1'b0;
    end else if (!cs_n) begin
      cnt_reg <= started_reg ? CNT_W'(cnt_reg + 1'b1) : CNT_W'(1);
      tog_reg <= started_reg ? tog_reg : ~tog_reg;
    end
  end

  // Shift in at the bottom; first edge starts from the diagnosis word
  always_ff @(negedge sclk) begin
    if (!cs_n) begin
      if (started_reg) begin
        sr_reg <= {sr_reg[FRAME_W-2:0], si_in};
      end else begin
        sr_reg <= {snap_reg[FRAME_W-2:0], si_in};
      end
    end
  end

  // Top bit leaves on the rising edge, passing chained data on
  always_ff @(posedge sclk or posedge cs_n or posedge link_clr_reg) begin
    if (cs_n || link_clr_reg) begin
      so_reg <= 1'b0;
    end else if (started_reg) begin
      so_reg <= sr_reg[FRAME_W-1];
    end else begin
      so_reg <= snap_reg[FRAME_W-1];
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------

  assign so_out     = so_reg;
  assign so_oe      = so_oe_reg;
  assign diag_flags = flags_reg;
  assign imr_word   = imr_reg;
  assign frame_bad  = bad_reg;
  assign frame_lost = lost_reg;

endmodule

`default_nettype wire

// *** ssdc_slave_assertions.sv ***
// Checker: link, frame and flag behaviour of the serial slave front end
`timescale 1ns/10ps
`default_nettype none
module ssdc_slave_chk (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  // Link pins
  input wire logic                  sclk,
  input wire logic                  cs_n,
  input wire logic                  si_in,
  input wire logic                  so_out,
  input wire logic                  so_oe,
  // Diagnosis
  input wire ssdc_pkg::ssdc_diag_t  diag_evt,
  input wire ssdc_pkg::ssdc_diag_t  diag_flags,
  // Commands and status
  input wire logic                  cmd_valid,
  input wire logic                  cmd_ready,
  input wire ssdc_pkg::ssdc_frame_t cmd_word,
  input wire ssdc_pkg::ssdc_frame_t imr_word,
  input wire logic                  frame_bad,
  input wire logic                  frame_lost
);
  import ssdc_pkg::*;
  // All checks run on the system clock
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_so_zero_desel: assert property (cs_n |-> !so_out)
    else $error("so_out driven while deselected");
  a_oe_off_desel: assert property (cs_n [*6] |-> !so_oe)
    else $error("so_oe still high long after deselect");
  a_oe_rise_lag: assert property ($fell(cs_n) |-> ##[2:5] so_oe)
    else $error("so_oe did not rise after select");
  a_oe_needs_sel: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n, 2))
    else $error("so_oe rose without select");
  a_bad_keeps_imr: assert property (frame_bad |-> $stable(imr_word) ##1 $stable(imr_word))
    else $error("imr changed on rejected frame");
  a_bad_no_push: assert property (frame_bad && !cmd_valid |=> !cmd_valid)
    else $error("rejected frame reached the buffer");
  a_bad_one_pulse: assert property (frame_bad |=> !frame_bad)
    else $error("frame_bad longer than one cycle");
  a_flags_cleared: assert property ($changed(imr_word) && !(|diag_evt) && !(|$past(diag_evt))
    |-> diag_flags == '0)
    else $error("flags not cleared on accepted frame");
  a_flag_latch: assert property ((|diag_evt)
    |=> (diag_flags & $past(diag_evt)) == $past(diag_evt))
    else $error("event not latched into flags");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word))
    else $error("command word dropped before taken");
  // Main scenarios reached
  c_bad: cover property (frame_bad);
  c_lost: cover property (frame_lost);
  c_take: cover property (cmd_valid && cmd_ready);
endmodule
bind ssdc_slave ssdc_slave_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
  .cs_n(cs_n), .si_in(si_in), .so_out(so_out), .so_oe(so_oe), .diag_evt(diag_evt),
  .diag_flags(diag_flags), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_word(cmd_word), .imr_word(imr_word), .frame_bad(frame_bad), .frame_lost(frame_lost));
`default_nettype wire

// *** ssdc_host_mdl.sv ***
// Host model: serial bus master driving select, clock and data
`timescale 1ns/10ps
`default_nettype none
module ssdc_host_mdl (
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      si_in,
  input  wire logic so_w
);
  // Idle: deselected, clock parked low
  initial begin
    sclk  = 1'b0;
    cs_n  = 1'b1;
    si_in = 1'b0;
  end
  // One frame of n clocks, bit n-1 first; rd collects the returned bits
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] rd);
    rd = '0;
    #7 cs_n = 1'b0;
    #250;
    for (int i = n - 1; i >= 0; i--) begin
      si_in = w[i];
      #20 sclk = 1'b1;
      #24 rd = {rd[46:0], so_w};
      sclk = 1'b0;
      #4;
    end
    // Lag, release with clock low, then minimum deselect time
    #250 cs_n = 1'b1;
    #250 si_in = ~si_in;
  endtask
  // Clock and data activity while deselected; the device must ignore it
  task automatic idle_clk(input int n);
    for (int i = 0; i < n; i++) begin
      si_in = ~si_in;
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    #20;
  endtask
endmodule
`default_nettype wire

// *** ssdc_tb.sv ***
// Testbench: scenarios for the serial slave front end
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  import ssdc_pkg::*;
  logic        clk_sys = 1'b0;  // System clock
  logic        rst_n = 1'b0;    // Reset, active low
  wire logic   sclk;            // Link clock from host
  wire logic   cs_n;            // Select from host
  wire logic   si_in;           // Data towards device
  wire logic   so_w;            // Resolved output wire
  logic        so_out;
  logic        so_oe;
  logic        so_q = 1'b0;     // Last driven output bit
  ssdc_diag_t  diag_evt = '0;
  ssdc_diag_t  diag_flags;
  logic        cmd_valid;
  logic        cmd_ready = 1'b0;
  ssdc_frame_t cmd_word;
  ssdc_frame_t imr_word;
  logic        frame_bad;
  logic        frame_lost;
  int          mismatches = 0;
  int          n_tests = 0;
  int          n_bad = 0;
  int          n_lost = 0;
  int          cyc = 0;
  logic [47:0] rd;
  logic [15:0] w;
  // Released wire shows the inverse of its last driven level
  assign so_w = (so_oe === 1'b1) ? so_out : ~so_q;
  always #10 clk_sys = ~clk_sys;
  ssdc_host_mdl mdl (.sclk(sclk), .cs_n(cs_n), .si_in(si_in), .so_w(so_w));
  ssdc_slave dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si_in(si_in),
    .so_out(so_out), .so_oe(so_oe), .diag_evt(diag_evt), .diag_flags(diag_flags),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word), .imr_word(imr_word),
    .frame_bad(frame_bad), .frame_lost(frame_lost));
  // Pulse counters, last output bit and hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (frame_bad === 1'b1) n_bad++;
    if (frame_lost === 1'b1) n_lost++;
    if (so_oe === 1'b1) so_q <= so_out;
    if (cyc == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // Verdict
  task automatic report_and_stop();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Take one word from the command output and compare it
  task automatic pop(input logic [15:0] e);
    int k;
    #1;
    for (k = 0; k < 20 && cmd_valid !== 1'b1; k++) @(posedge clk_sys) #1;
    `CHK("cmd_word", e, cmd_word)
    @(posedge clk_sys) cmd_ready <= 1'b1;
    @(posedge clk_sys) cmd_ready <= 1'b0;
  endtask
  // Diagnosis snapshot shifted out, frame accepted, flags cleared
  task automatic t_single();
    @(posedge clk_sys) diag_evt <= '{prot: 8'h0C, open_load: 8'h02, short_gnd: 8'h09};
    @(posedge clk_sys) diag_evt <= '0;
    repeat (3) @(posedge clk_sys);
    `CHK("flags set", 24'h0C0209, diag_flags)
    mdl.xfer(48'h0000_0000_C3A5, 16, rd);
    `CHK("so word", 16'hFF24, rd[15:0])
    `CHK("imr", 16'hC3A5, imr_word)
    `CHK("flags clr", 24'h000000, diag_flags)
    `CHK("oe off", 1'b0, so_oe)
    pop(16'hC3A5);
  endtask
  // Frames of bad length are dropped and keep imr and flags
  task automatic t_bad();
    int lens[3] = '{0, 7, 12};
    int b0;
    @(posedge clk_sys) diag_evt <= '{prot: 8'h80, open_load: 8'h00, short_gnd: 8'h00};
    @(posedge clk_sys) diag_evt <= '0;
    // Eight stray clocks while deselected must not count towards a frame
    mdl.idle_clk(8);
    `CHK("oe desel", 1'b0, so_oe)
    foreach (lens[i]) begin
      b0 = n_bad;
      mdl.xfer(48'h0000_0000_0FFF, lens[i], rd);
      `CHK("bad pulse", b0 + 1, n_bad)
      `CHK("imr kept", 16'hC3A5, imr_word)
      `CHK("flags kept", 24'h800000, diag_flags)
    end
    `CHK("no push", 1'b0, cmd_valid)
  endtask
  // Two words through one device: first word comes back out
  task automatic t_chain();
    mdl.xfer(48'h0000_1234_5678, 32, rd);
    `CHK("chain diag", 16'hBFFF, rd[31:16])
    `CHK("chain pass", 16'h1234, rd[15:0])
    `CHK("chain imr", 16'h5678, imr_word)
    pop(16'h5678);
  endtask
  // Fill the buffer past its depth, then drain in order
  task automatic t_fifo();
    for (int i = 0; i < 10; i++) begin
      w = 16'hA000 + 16'(i);
      mdl.xfer({32'h0000_0000, w}, 16, rd);
      if (i == 8) `CHK("no loss", 0, n_lost)
    end
    `CHK("lost", 1, n_lost)
    `CHK("imr last", 16'hA009, imr_word)
    for (int i = 0; i < 9; i++) pop(16'hA000 + 16'(i));
    repeat (2) @(posedge clk_sys);
    `CHK("empty", 1'b0, cmd_valid)
  endtask
  // Reset in mid-run returns the outputs to defaults, then a frame works
  task automatic t_reset();
    @(posedge clk_sys) diag_evt <= '{prot: 8'h00, open_load: 8'h10, short_gnd: 8'h00};
    @(posedge clk_sys) diag_evt <= '0;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("mid imr", 16'h0000, imr_word)
    `CHK("mid flags", 24'h000000, diag_flags)
    `CHK("mid valid", 1'b0, cmd_valid)
    `CHK("mid oe", 1'b0, so_oe)
    @(posedge clk_sys) rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    mdl.xfer(48'h0000_0000_3C5A, 16, rd);
    `CHK("mid so", 16'hFFFF, rd[15:0])
    `CHK("mid imr new", 16'h3C5A, imr_word)
    pop(16'h3C5A);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    `CHK("rst imr", 16'h0000, imr_word)
    `CHK("rst flags", 24'h000000, diag_flags)
    `CHK("rst valid", 1'b0, cmd_valid)
    `CHK("rst oe", 1'b0, so_oe)
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_single();
    t_bad();
    t_chain();
    t_fifo();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
